// ===== hdl/tcs_tx_pcs.sv
// Purpose: transmit coding datapath, fabric words to serial bit pairs
// Assumes: fabric logic on core_clk, Avalon-MM slave for control and status
// Notes: one code group per serializer tick; idle sends commas with encoder on, zeros with it off
`timescale 1ns/1ps
// Overview of operation
// R1: byte serializer takes double-width word, emits two halves on consecutive words
// R2: width halving is selectable; fabric must enable it above its clock limit
// R3: lower half goes out first, upper half on the next word
// R4: encoder maps byte plus control flag to ten bits with correct disparity
// R5: control flag high gives a K group, low gives a D group
// R6: fabric raises control flag only for valid special characters
// R7: during digital reset fabric input is ignored and negative K28.5 repeats
// R8: after reset release start negative disparity and send three K28.5 groups
// R9: pipeline may carry undefined groups before the three sync commas
// R10: forced disparity uses the given value, low positive, high negative
// R11: unforced repeated groups alternate variants keeping disparity neutral
// R12: polarity inversion flips every bit of the serializer word
// R13: downstream receiver tolerates disparity errors when inversion changes
// R14: bit reversal swaps the serializer word end to end
// R15: bit flip reverses bits inside each input byte at the input
// R16: bit slip delays serializer data by the programmed number of bits
// R17: serializer sends each word least significant bit first
// R18: serializer emits one bit per clock edge, half the line rate
// R19: encoder follows the standard 8b/10b tables and disparity rules
// R20: with encoder off words pass raw, still inverted, reversed and slipped
module tcs_tx_pcs
  import tcs_pkg::*;
#(
  parameter int LANE_W = TCS_LANE_W
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire tcs_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic ser_tick,
  output logic [1:0] ser_bits
);
  // ==========================================================================
  // elaboration check
  if (LANE_W != TCS_LANE_W)
  begin : g_bad_width
    $error("lane width must be ten");
  end

  typedef struct packed {
    logic [9:0] code;
    logic rd;
    logic [1:0] sync;
    logic phase;
    tcs_lane_t hold;
    tcs_cfg_t cfg;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] cnt;
  } tcs_st_t;
  tcs_st_t st_q, st_d;

  tcs_word_t fw;
  tcs_lane_t lane;
  logic have_in;
  logic req;
  logic [9:0] ser_word;

  // ==========================================================================
  // input bit flip per byte
  genvar gi;
  for (gi = 0; gi < TCS_LANES; gi++)
  begin : g_flip
    logic [9:0] fr;
    assign fr = tcs_rev({2'h0, tx_word.lane[gi].data[7:0]}, 8);
    assign fw.lane[gi] = st_q.cfg.flip ? {tx_word.lane[gi][12:8], fr[7:0]}
      : tx_word.lane[gi]; // [R15]
  end

  // ==========================================================================
  // 8b/10b encoder
  function automatic tcs_enc_t encode(input logic [7:0] d, input logic k, input logic rd);
    tcs_enc_t r;
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] six;
    logic [3:0] four;
    logic unb6;
    logic unb4;
    logic mid;
    logic alt;
    logic [9:0] r4;
    logic [9:0] r6;
    x = d[4:0];
    y = d[7:5];
    six = (k && x == TCS_X_K28) ? TCS_6B_K28 : TCS_6B[x]; // [R5] [R19]
    unb6 = ($countones(six) != 3);
    if (rd && (unb6 || x == 5'h07))
    begin
      six = ~six; // [R4]
    end
    mid = rd ^ unb6;
    alt = (y == 3'h7) && (k || (!mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
      || (mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e))); // [R19]
    four = alt ? TCS_4B_ALT7 : TCS_4B[y];
    if (k && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6))
    begin
      four = ~four; // [R5]
    end
    unb4 = ($countones(four) != 2);
    if (mid && (unb4 || y == 3'h3 || k))
    begin
      four = ~four; // [R4]
    end
    r4 = tcs_rev({6'h00, four}, 4);
    r6 = tcs_rev({4'h0, six}, 6);
    r.code = {r4[3:0], r6[5:0]};
    r.rd = mid ^ unb4; // [R11]
    return r;
  endfunction : encode

  // ==========================================================================
  // sequencing
  assign lane = st_q.phase ? st_q.hold : fw.lane[0];
  assign have_in = st_q.phase | tx_valid;
  assign tx_ready = ser_tick & ~st_q.cfg.dreset & (st_q.sync == 2'h0) & ~st_q.phase; // [R1]
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~st_q.ack;
  assign avs_readdata = st_q.rdata;

  always_comb
  begin
    tcs_enc_t e;
    e = '0;
    st_d = st_q;
    if (ser_tick)
    begin
      if (st_q.cfg.dreset)
      begin
        st_d.code = TCS_K285_NEG; // [R7]
        st_d.rd = 1'b0;
        st_d.sync = TCS_SYNC_CNT; // [R8]
        st_d.phase = 1'b0;
      end
      else if (st_q.sync != 2'h0)
      begin
        e = encode(TCS_K285_BYTE, 1'b1, st_q.rd); // [R8]
        st_d.code = e.code;
        st_d.rd = e.rd;
        st_d.sync = st_q.sync - 2'h1;
      end
      else if (have_in)
      begin
        if (st_q.cfg.enc)
        begin
          e = encode(lane.data[7:0], lane.ctrl,
            lane.fdisp ? ~lane.dval : st_q.rd); // [R10] [R4]
          st_d.code = e.code;
          st_d.rd = e.rd;
        end
        else
        begin
          st_d.code = st_q.cfg.w8 ? {2'h0, lane.data[7:0]} : lane.data; // [R20]
        end
        if (st_q.phase)
        begin
          st_d.phase = 1'b0; // [R3]
        end
        else if (st_q.cfg.byteser)
        begin
          st_d.phase = 1'b1; // [R1] [R2]
          st_d.hold = fw.lane[1]; // [R3]
        end
        st_d.cnt = st_q.cnt + 16'h0001;
      end
      else if (st_q.cfg.enc)
      begin
        e = encode(TCS_K285_BYTE, 1'b1, st_q.rd); // [R11]
        st_d.code = e.code;
        st_d.rd = e.rd;
      end
      else
      begin
        st_d.code = '0;
      end
    end
    // register bus
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack)
    begin
      case (avs_address)
        TCS_OFF_CTRL: st_d.rdata = {20'h0_0000, 4'(st_q.cfg >> 7), 1'b0,
          7'(st_q.cfg)};
        TCS_OFF_STAT: st_d.rdata = {st_q.cnt, 13'h0000, st_q.phase,
          (st_q.sync == 2'h0), st_q.rd};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && st_q.ack && avs_address == TCS_OFF_CTRL)
    begin
      st_d.cfg.dreset = avs_writedata[TCS_B_DRESET];
      st_d.cfg.byteser = avs_writedata[TCS_B_BYTESER]; // [R2]
      st_d.cfg.enc = avs_writedata[TCS_B_ENC];
      st_d.cfg.w8 = avs_writedata[TCS_B_W8];
      st_d.cfg.inv = avs_writedata[TCS_B_INV];
      st_d.cfg.rev = avs_writedata[TCS_B_REV];
      st_d.cfg.flip = avs_writedata[TCS_B_FLIP];
      st_d.cfg.slip = avs_writedata[TCS_B_SLIP +: 4];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.code <= TCS_K285_NEG;
      st_q.sync <= TCS_SYNC_CNT;
      st_q.cfg <= tcs_cfg_t'({TCS_CTRL_RST[11:8], TCS_CTRL_RST[6:0]});
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // line side
  tcs_bit_proc u_bit_proc (
    .core_clk(core_clk),
    .rst(rst),
    .tick(ser_tick),
    .w8(st_q.cfg.w8 & ~st_q.cfg.enc),
    .inv(st_q.cfg.inv),
    .rev(st_q.cfg.rev),
    .slip(st_q.cfg.slip),
    .word_in(st_q.code), // [R9]
    .word_out(ser_word)
  );

  tcs_serializer u_serializer (
    .core_clk(core_clk),
    .rst(rst),
    .w8(st_q.cfg.w8 & ~st_q.cfg.enc),
    .word(ser_word),
    .tick(ser_tick),
    .ser_bits(ser_bits)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_comma: assert property (ser_tick && st_q.cfg.dreset |=> st_q.code == TCS_K285_NEG
    && st_q.rd == 1'b0) // [R7]
    else $error("reset comma not negative K28.5");
  a_sync_start_neg: assert property (ser_tick && !st_q.cfg.dreset && st_q.sync == 2'h3
    |-> st_q.rd == 1'b0) // [R8]
    else $error("sync does not start negative");
  a_sync_commas: assert property (ser_tick && !st_q.cfg.dreset && st_q.sync != 2'h0
    |=> st_q.code == TCS_K285_NEG || st_q.code == TCS_K285_POS) // [R8]
    else $error("sync group not K28.5");
  a_ready_low_half: assert property (tx_ready && tx_valid && st_q.cfg.byteser
    |=> st_q.phase && st_q.hold == $past(fw.lane[1])) // [R1] [R3]
    else $error("upper half not held");
  a_high_follows: assert property (ser_tick && st_q.phase && !st_q.cfg.dreset
    |=> !st_q.phase && !tx_ready) // [R1]
    else $error("upper half not sent next");
  a_force_pos: assert property (ser_tick && tx_ready && tx_valid && st_q.cfg.enc
    && lane.ctrl && lane.data[7:0] == TCS_K285_BYTE && lane.fdisp && !lane.dval
    |=> st_q.code == TCS_K285_POS) // [R10]
    else $error("forced positive K28.5 wrong");
  a_rd_alternate: assert property (ser_tick && tx_ready && tx_valid && st_q.cfg.enc
    && lane.ctrl && lane.data[7:0] == TCS_K285_BYTE && !lane.fdisp
    |=> st_q.code == ($past(st_q.rd) ? TCS_K285_POS : TCS_K285_NEG)
    && st_q.rd != $past(st_q.rd)) // [R11] [R19]
    else $error("running disparity not kept");
  a_bus_answer: assert property (req && !st_q.ack |=> !avs_waitrequest || !req)
    else $error("bus answer late");
endmodule : tcs_tx_pcs

// ===== hdl/tcs_pkg.sv
// Purpose: shared constants, carriers and helpers of the transmit coding datapath
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes: code group bit 0 is the first bit on the line
package tcs_pkg;
  // ==========================================================================
  // widths and counts
  localparam int TCS_LANE_W = 10;
  localparam int TCS_LANES = 2;
  localparam logic [1:0] TCS_SYNC_CNT = 2'h3;
  localparam logic [3:0] TCS_SLIP_MAX10 = 4'h9;
  localparam logic [3:0] TCS_SLIP_MAX8 = 4'h7;
  localparam logic [2:0] TCS_HALF10 = 3'h4;
  localparam logic [2:0] TCS_HALF8 = 3'h3;
  // ==========================================================================
  // register map
  localparam logic [3:0] TCS_OFF_CTRL = 4'h0;
  localparam logic [3:0] TCS_OFF_STAT = 4'h4;
  localparam int TCS_B_DRESET = 0;
  localparam int TCS_B_BYTESER = 1;
  localparam int TCS_B_ENC = 2;
  localparam int TCS_B_W8 = 3;
  localparam int TCS_B_INV = 4;
  localparam int TCS_B_REV = 5;
  localparam int TCS_B_FLIP = 6;
  localparam int TCS_B_SLIP = 8;
  localparam logic [31:0] TCS_CTRL_RST = 32'h0000_0004;
  // ==========================================================================
  // code constants
  localparam logic [9:0] TCS_K285_NEG = 10'h17c;
  localparam logic [9:0] TCS_K285_POS = 10'h283;
  localparam logic [7:0] TCS_K285_BYTE = 8'hbc;
  localparam logic [4:0] TCS_X_K28 = 5'h1c;
  localparam logic [5:0] TCS_6B_K28 = 6'h0f;
  localparam logic [3:0] TCS_4B_ALT7 = 4'h7;
  // abcdei, a in msb, current disparity negative
  localparam logic [5:0] TCS_6B [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // fghj, f in msb, current disparity negative
  localparam logic [3:0] TCS_4B [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic ctrl;
    logic fdisp;
    logic dval;
    logic [9:0] data;
  } tcs_lane_t;
  typedef struct packed {
    tcs_lane_t [1:0] lane;
  } tcs_word_t;
  typedef struct packed {
    logic [3:0] slip;
    logic flip;
    logic rev;
    logic inv;
    logic w8;
    logic enc;
    logic byteser;
    logic dreset;
  } tcs_cfg_t;
  typedef struct packed {
    logic [9:0] code;
    logic rd;
  } tcs_enc_t;
  // ==========================================================================
  // reverse the low n bits of v
  function automatic logic [9:0] tcs_rev(input logic [9:0] v, input int n);
    logic [9:0] r;
    r = '0;
    for (int i = 0; i < 10; i++)
    begin
      if (i < n)
      begin
        r[i] = v[n-1-i];
      end
    end
    return r;
  endfunction : tcs_rev
endpackage : tcs_pkg

// ===== hdl/tcs_bit_proc.sv
// Purpose: slip, bit reversal and polarity inversion ahead of the serializer
// Assumes: word_in is valid at tick, prior word held for slipping
// Notes: slip above width minus one is clamped
`timescale 1ns/1ps
module tcs_bit_proc
  import tcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic w8,
  input wire logic inv,
  input wire logic rev,
  input wire logic [3:0] slip,
  input wire logic [9:0] word_in,
  output logic [9:0] word_out
);
  typedef struct packed {
    logic [9:0] prev;
  } tcs_bp_st_t;
  tcs_bp_st_t st_q, st_d;
  logic [3:0] s;
  logic [19:0] cat;
  logic [19:0] sh;
  logic [9:0] sl;
  logic [9:0] rv;

  // ==========================================================================
  // datapath
  always_comb
  begin
    st_d = st_q;
    if (tick)
    begin
      st_d.prev = word_in;
    end
    if (w8)
    begin
      s = (slip > TCS_SLIP_MAX8) ? TCS_SLIP_MAX8 : slip;
      cat = {4'h0, word_in[7:0], st_q.prev[7:0]};
      sh = cat >> (5'd8 - {1'b0, s}); // [R16]
      sl = {2'h0, sh[7:0]};
      rv = rev ? tcs_rev(sl, 8) : sl; // [R14]
      word_out = inv ? {2'h0, ~rv[7:0]} : rv; // [R12]
    end
    else
    begin
      s = (slip > TCS_SLIP_MAX10) ? TCS_SLIP_MAX10 : slip;
      cat = {word_in, st_q.prev};
      sh = cat >> (5'd10 - {1'b0, s}); // [R16]
      sl = sh[9:0];
      rv = rev ? tcs_rev(sl, 10) : sl; // [R14]
      word_out = inv ? ~rv : rv; // [R12]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_invert_all: assert property (inv && !rev && slip == 4'h0 && !w8 |-> word_out == ~word_in) // [R12]
    else $error("polarity inversion missing");
  a_reverse_ends: assert property (rev && !inv && slip == 4'h0 && !w8
    |-> word_out[0] == word_in[9] && word_out[9] == word_in[0]) // [R14]
    else $error("bit reversal wrong");
  a_slip_delay: assert property (tick && slip == 4'h1 && !w8 && !rev && !inv
    |=> slip != 4'h1 || w8 || rev || inv || word_out[0] == $past(word_in[9])) // [R16]
    else $error("slip of one bit wrong");
endmodule : tcs_bit_proc

// ===== hdl/tcs_serializer.sv
// Purpose: parallel to serial, two bits per clock, first bit in bit 0
// Assumes: one clock edge pair per two line bits
// Notes: tick marks the cycle in which a new word is loaded
`timescale 1ns/1ps
module tcs_serializer
  import tcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic w8,
  input wire logic [9:0] word,
  output logic tick,
  output logic [1:0] ser_bits
);
  typedef struct packed {
    logic [9:0] sr;
    logic [2:0] cnt;
    logic [1:0] bits;
  } tcs_ser_st_t;
  tcs_ser_st_t st_q, st_d;

  // ==========================================================================
  // shift two bits per clock, lsb first
  assign tick = (st_q.cnt == 3'h0);
  assign ser_bits = st_q.bits;

  always_comb
  begin
    st_d = st_q;
    if (tick)
    begin
      st_d.bits = word[1:0]; // [R17] [R18]
      st_d.sr = {2'h0, word[9:2]};
      st_d.cnt = w8 ? TCS_HALF8 : TCS_HALF10;
    end
    else
    begin
      st_d.bits = st_q.sr[1:0]; // [R17]
      st_d.sr = {2'h0, st_q.sr[9:2]};
      st_d.cnt = st_q.cnt - 3'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_lsb_first: assert property (tick |=> ser_bits == $past(word[1:0]) ##1
    ser_bits == $past(word[3:2], 2)) // [R17]
    else $error("serial order not lsb first");
  a_word_period: assert property (tick && !w8 |=> !tick [*4] ##1 tick) // [R18]
    else $error("ten bit word period wrong");
endmodule : tcs_serializer

// ===== tb/tcs_fabric_src.sv
// Purpose: fabric side source of transmit words
// Assumes: words queued by the bench, taken at an edge with tx_valid and tx_ready
// Notes: released data lines toggle every cycle
`timescale 1ns/1ps
module tcs_fabric_src
  import tcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic tx_ready,
  output tcs_word_t tx_word,
  output logic tx_valid
);
  // ====
  // queue and handshake
  tcs_word_t q[$];

  task automatic push(input tcs_word_t w);
    q.push_back(w);
  endtask : push

  initial
  begin
    tx_word = '0;
    tx_valid = 1'b0;
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_valid <= 1'b0;
    end
    else if (!tx_valid || tx_ready)  // word held until taken
    begin
      if (tx_valid)
      begin
        void'(q.pop_front());
      end
      if (q.size() > 0 && !stall)
      begin
        tx_word <= q[0];
        tx_valid <= 1'b1;
      end
      else
      begin
        tx_word <= ~tx_word;
        tx_valid <= 1'b0;
      end
    end
  end
endmodule : tcs_fabric_src

// ===== tb/tb.sv
// Purpose: self-checking bench of the transmit coding datapath
// Assumes: line words rebuilt from bit pairs, two ticks behind the code choice
// Notes: comparisons pause for a few words after each control write
`timescale 1ns/1ps
module tb
  import tcs_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  tcs_word_t tx_word;
  logic tx_valid;
  logic tx_ready;
  logic ser_tick;
  logic [1:0] ser_bits;
  logic stall = 1'b0;
  logic [31:0] ctrl_m = 32'h0000_0004;
  logic [31:0] ctrl_p = 32'h0000_0004;
  logic [31:0] rdv;
  logic [9:0] acc, prev_m, e, msk;
  logic [9:0] exq[$];
  logic [1:0] sync_m;
  logic rd_m, pend_m;
  tcs_lane_t up_m;
  int n_bits, skip, miscompares = 0, total_checks = 0, seed = 32'h5b7b;
  int n_half_m;
  logic [7:0] kt [12] = '{8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc, 8'hdc, 8'hfc,
    8'hf7, 8'hfb, 8'hfd, 8'hfe};
  logic [31:0] raw_cfg [11] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_0020,
    32'h0000_0040, 32'h0000_0300, 32'h0000_0900, 32'h0000_0f00, 32'h0000_0008,
    32'h0000_0028, 32'h0000_0718, 32'h0000_0100};

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk)
    stall <= ($random(seed) & 3) == 0;

  tcs_tx_pcs DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .ser_tick(ser_tick), .ser_bits(ser_bits));

  tcs_fabric_src u_src (.core_clk(core_clk), .rst(rst), .stall(stall),
    .tx_ready(tx_ready), .tx_word(tx_word), .tx_valid(tx_valid));

  // ====
  // reference coding
  function automatic logic [9:0] enc8(input logic [7:0] b, input logic k,
    input logic fd, input logic dv);
    logic [5:0] s;
    logic [3:0] f;
    logic r;
    logic [9:0] c;
    r = fd ? !dv : rd_m;
    s = (k && b[4:0] == TCS_X_K28) ? TCS_6B_K28 : TCS_6B[b[4:0]];
    if (r && ($countones(s) != 3 || s == 6'h38))
      s = ~s;
    if ($countones(s) != 3)
      r = !r;
    f = TCS_4B[b[7:5]];
    if (b[7:5] == 3'h7 && (k || (!r && b[4:0] inside {5'h11, 5'h12, 5'h14})
      || (r && b[4:0] inside {5'h0b, 5'h0d, 5'h0e})))
      f = TCS_4B_ALT7;
    if (r && ($countones(f) != 2 || f == 4'hc))
      f = ~f;
    else if (!r && k && b[4:0] == TCS_X_K28 && $countones(f) == 2 && f != 4'hc)
      f = ~f;
    if ($countones(f) != 2)
      r = !r;
    for (int i = 0; i < 6; i++)
      c[i] = s[5 - i];
    for (int i = 0; i < 4; i++)
      c[6 + i] = f[3 - i];
    rd_m = r;
    return c;
  endfunction : enc8

  function automatic logic [9:0] lane_code(input tcs_lane_t l);
    logic [9:0] d;
    d = l.data;
    if (ctrl_m[TCS_B_FLIP])
      for (int i = 0; i < 8; i++)
        d[i] = l.data[7 - i];
    if (!ctrl_m[TCS_B_ENC])
      return ctrl_m[TCS_B_W8] ? {2'b00, d[7:0]} : d;
    return enc8(d[7:0], l.ctrl, l.fdisp, l.dval);
  endfunction : lane_code

  function automatic logic [9:0] proc(input logic [9:0] c);
    int w, s;
    logic [19:0] cat;
    logic [9:0] v;
    w = (ctrl_m[TCS_B_W8] && !ctrl_m[TCS_B_ENC]) ? 8 : 10;
    v = c & msk;
    if (ctrl_m[TCS_B_REV])
      for (int i = 0; i < w; i++)
        v[i] = c[w - 1 - i];
    if (ctrl_m[TCS_B_INV])
      v = ~v & msk;
    s = int'(ctrl_m[TCS_B_SLIP +: 4]);
    if (s > w - 1)
      s = w - 1;
    cat = (20'(v) << w) | 20'(prev_m);
    prev_m = v;
    return 10'((cat >> (w - s)) & 20'(msk));
  endfunction : proc

  // ====
  // checks and report
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // ====
  // stream model, compared at every word except those skipped after a control change
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      exq.delete();
      sync_m = TCS_SYNC_CNT;
      rd_m = 1'b0;
      pend_m = 1'b0;
      skip = 0;
      n_half_m = 0;
      n_bits = 0;
      acc = '0;
      prev_m = '0;
    end
    else
    begin
      check("tx_ready", 32'(ser_tick && !ctrl_m[TCS_B_DRESET] && sync_m == 0 && !pend_m),
        32'(tx_ready));
      acc = acc | (10'(ser_bits) << n_bits);
      n_bits += 2;
      if (ser_tick)
      begin
        if (ctrl_p != ctrl_m)
          skip = ((ctrl_p ^ ctrl_m) == 32'h0000_0001) ? 2 : 3;
        ctrl_p = ctrl_m;
        msk = (ctrl_m[TCS_B_W8] && !ctrl_m[TCS_B_ENC]) ? 10'h0ff : 10'h3ff;
        if (ctrl_m[TCS_B_DRESET])
        begin
          e = TCS_K285_NEG;
          rd_m = 1'b0;
          sync_m = TCS_SYNC_CNT;
          pend_m = 1'b0;
        end
        else if (sync_m != 0)
        begin
          e = enc8(TCS_K285_BYTE, 1'b1, 1'b0, 1'b0);
          sync_m--;
        end
        else if (pend_m)
        begin
          e = lane_code(up_m);
          pend_m = 1'b0;
          n_half_m++;
        end
        else if (tx_valid && tx_ready)
        begin
          e = lane_code(tx_word.lane[0]);
          up_m = tx_word.lane[1];
          pend_m = ctrl_m[TCS_B_BYTESER];
          n_half_m++;
        end
        else
          e = ctrl_m[TCS_B_ENC] ? enc8(TCS_K285_BYTE, 1'b1, 1'b0, 1'b0) : 10'h000;
        exq.push_back(proc(e));
        if (exq.size() > 2)
        begin
          e = exq.pop_front();
          if (skip > 0)
            skip--;
          else
            check("line word", 32'(e), 32'(acc & msk));
        end
        acc = '0;
        n_bits = 0;
      end
    end
  end

  // ====
  // bus, stimulus and flush
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0)
    begin
      miscompares++;
      end_of_test();
    end
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wr && a == TCS_OFF_CTRL)
      ctrl_m <= wd;
  endtask : bus

  task automatic send(input int n, input logic mix);
    tcs_word_t w;
    for (int i = 0; i < n; i++)
    begin
      w = 26'($random(seed));
      for (int j = 0; j < 2; j++)
      begin
        w.lane[j].ctrl = mix & w.lane[j].ctrl;
        w.lane[j].fdisp = mix & w.lane[j].fdisp;
        if (w.lane[j].ctrl)
          w.lane[j].data[7:0] = kt[($random(seed) & 32'h7fff_ffff) % 12];
      end
      u_src.push(w);
    end
  endtask : send

  task automatic drain(input string name);
    int n;
    n = 0;
    while ((u_src.q.size() > 0 || tx_valid) && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000)
    begin
      miscompares++;
      end_of_test();
    end
    repeat (15) @(posedge core_clk);
    $display("test %s done, checks %0d, miscompares %0d", name, total_checks, miscompares);
  endtask : drain

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, TCS_OFF_CTRL, '0);
    check("ctrl reset", 32'h0000_0004, rdv);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, '0);
    check("unmapped read", 32'h0000_0000, rdv);
    bus(1'b0, TCS_OFF_CTRL, '0);
    check("ctrl kept", 32'h0000_0004, rdv);
    send(40, 1'b0);
    drain("data coding");
    send(60, 1'b1);
    drain("specials and forced disparity");
    bus(1'b0, TCS_OFF_STAT, '0);
    check("stat sync done", 32'h0000_0002, rdv & 32'h0000_0006);
    check("stat halves", 32'(n_half_m[15:0]), 32'(rdv[31:16]));
    bus(1'b1, TCS_OFF_CTRL, 32'h0000_0005);
    send(6, 1'b0);
    repeat (40) @(posedge core_clk);
    bus(1'b1, TCS_OFF_CTRL, 32'h0000_0004);
    drain("soft reset");
    bus(1'b1, TCS_OFF_CTRL, 32'h0000_0006);
    send(40, 1'b1);
    drain("byte serializer");
    foreach (raw_cfg[i])
    begin
      bus(1'b1, TCS_OFF_CTRL, raw_cfg[i]);
      send(12, 1'b0);
      drain("raw options");
    end
    end_of_test();
  end
endmodule : tb
